/* core/ifdt_pkg.sv */
// Constants and types shared by the instruction field decoder
package ifdt_pkg;
  localparam logic [7:0] A_INSTR = 8'h00;
  localparam logic [7:0] A_FLAGS = 8'h04;
  localparam logic [7:0] A_OPND = 8'h08;
  localparam logic [7:0] A_STRCFG = 8'h0C;
  localparam logic [7:0] A_FLO = 8'h10;
  localparam logic [7:0] A_FHI = 8'h14;
  localparam logic [7:0] A_FCTRL = 8'h18;
  localparam logic [7:0] A_DEC = 8'h20;
  localparam logic [7:0] A_IMM = 8'h24;
  localparam logic [7:0] A_TEA = 8'h28;
  localparam logic [7:0] A_TOTAL = 8'h2C;
  localparam logic [7:0] A_STRST = 8'h30;
  localparam logic [7:0] A_FSTAT = 8'h34;
  localparam logic [7:0] A_RLO = 8'h38;
  localparam logic [7:0] A_RHI = 8'h3C;
  localparam logic [2:0] SZ_WORD = 3'h2;
  localparam logic [31:0] RST_WORD = 32'h00000000;
  localparam logic [3:0] FMT0_KEY = 4'hA;
  localparam logic [1:0] FMT2_KEY = 2'h3;
  localparam logic [2:0] OP_F3 = 3'h7;
  localparam logic [1:0] LEN_B = 2'h0;
  localparam logic [1:0] LEN_W = 2'h1;
  localparam logic [1:0] LEN_D = 2'h3;
  localparam logic [1:0] REP_WHILE = 2'h1;
  localparam logic [1:0] REP_UNTIL = 2'h3;
  localparam logic [2:0] OP_ADD_QUICK = 3'h0;
  localparam logic [2:0] OP_COMPARE_QUICK = 3'h1;
  localparam logic [2:0] OP_SPR = 3'h2;
  localparam logic [2:0] OP_SCOND = 3'h3;
  localparam logic [2:0] OP_ACB = 3'h4;
  localparam logic [2:0] OP_MOVE_QUICK = 3'h5;
  localparam logic [2:0] OP_LPR = 3'h6;
  localparam logic [3:0] DR_USB = 4'h0;
  localparam logic [3:0] DR_FP = 4'h8;
  localparam logic [3:0] DR_SP = 4'h9;
  localparam logic [3:0] DR_SB = 4'hA;
  localparam logic [3:0] DR_PSR = 4'hD;
  localparam logic [3:0] DR_VTB = 4'hE;
  localparam logic [3:0] DR_DTP = 4'hF;
  localparam logic [7:0] T_REG = 8'h02;
  localparam logic [7:0] T_IMMABS = 8'h04;
  localparam logic [7:0] T_RELSP = 8'h05;
  localparam logic [7:0] T_TOS_R = 8'h02;
  localparam logic [7:0] T_TOS_W = 8'h04;
  localparam logic [7:0] T_TOS_M = 8'h03;
  localparam logic [7:0] T_SC_REG = 8'h05;
  localparam logic [7:0] T_SC_TOS = 8'h04;
  localparam logic [7:0] T_IX_B = 8'h05;
  localparam logic [7:0] T_IX_W = 8'h07;
  localparam logic [7:0] T_IX_D = 8'h08;
  localparam logic [7:0] T_IX_Q = 8'h0A;
  localparam logic [7:0] T_TOPB = 8'h03;
  localparam logic [7:0] T_BUSCYC = 8'h04;
  localparam logic [7:0] T_BUSADJ = 8'h01;
  localparam logic [4:0] HIDE_BW = 5'h0D;
  localparam logic [4:0] HIDE_D = 5'h04;
  typedef enum logic [3:0] {CC_EQ, CC_NE, CC_CS, CC_CC, CC_HI, CC_LS,
    CC_GT, CC_LE, CC_FS, CC_FC, CC_LO, CC_HS, CC_LT, CC_GE, CC_TRUE,
    CC_FALSE} ifdt_cc_t;
  typedef enum logic [2:0] {M_REG, M_IMM, M_ABS, M_REL, M_MSP, M_TOS,
    M_SCALED} ifdt_mode_t;
  typedef enum logic [1:0] {X_READ, X_WRITE, X_RMW} ifdt_acc_t;
  typedef struct packed {
    logic aux; logic sgt; logic above; logic borrow; logic eq;
  } ifdt_flags_t;
  typedef struct packed {
    logic [7:0] tcy; logic [2:0] rsv; logic rmw2;
    logic [1:0] nc2; logic [1:0] nc1;
    logic [1:0] sc2; logic [2:0] b2; logic [2:0] m2;
    logic [1:0] sc1; logic [2:0] b1; logic [2:0] m1;
  } ifdt_opnd_t;
  typedef struct packed {
    logic [4:0] waits; logic [1:0] pad; logic [1:0] kind;
    logic transl; logic back; logic [1:0] rep;
  } ifdt_str_t;
  typedef struct packed {
    logic quick; logic trap; logic dvalid; logic [3:0] dsel;
    logic cvalid; logic ctrue; logic fstd; logic [2:0] len1h;
  } ifdt_dec_t;
endpackage

/* core/ifdt_cond.sv */
// Branch and set condition evaluator against the status bits
`timescale 1ns/10ps
`default_nettype none
module ifdt_cond (
  input wire logic [3:0] code,
  input wire logic eq,
  input wire logic borrow,
  input wire logic above,
  input wire logic sgt,
  input wire logic aux,
  output logic hit
);
  import ifdt_pkg::*;
  always_comb begin
    case (ifdt_cc_t'(code))
      CC_EQ: hit = eq;
      CC_NE: hit = !eq;
      CC_CS: hit = borrow;
      CC_CC: hit = !borrow;
      CC_HI: hit = above;
      CC_LS: hit = !above;
      CC_GT: hit = sgt;
      CC_LE: hit = !sgt;
      CC_FS: hit = aux;
      CC_FC: hit = !aux;
      CC_LO: hit = !above && !eq;
      CC_HS: hit = above || eq;
      CC_LT: hit = !sgt && !eq;
      CC_GE: hit = sgt || eq;
      CC_TRUE: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

/* core/ifdt_tea.sv */
// Effective-address time of one operand
`timescale 1ns/10ps
`default_nettype none
module ifdt_tea (
  input wire logic [2:0] mode,
  input wire logic [2:0] base,
  input wire logic [1:0] scale,
  input wire logic [1:0] acc,
  output logic [7:0] tea
);
  import ifdt_pkg::*;
  logic [7:0] ti1;
  logic [7:0] ti2;
  function automatic logic [7:0] plain(input logic [2:0] m,
                                       input logic [1:0] a);
    case (ifdt_mode_t'(m))
      M_REG: plain = T_REG;
      M_IMM, M_ABS: plain = T_IMMABS;
      M_TOS: plain = (a == X_READ) ? T_TOS_R :
                     (a == X_RMW) ? T_TOS_M : T_TOS_W;
      default: plain = T_RELSP;
    endcase
  endfunction
  always_comb begin
    if (base == M_REG) begin
      ti1 = T_SC_REG;
    end else if (base == M_TOS) begin
      ti1 = T_SC_TOS;
    end else begin
      ti1 = plain(base, acc);
    end
    case (scale)
      2'h0: ti2 = T_IX_B;
      2'h1: ti2 = T_IX_W;
      2'h2: ti2 = T_IX_D;
      default: ti2 = T_IX_Q;
    endcase
    tea = (mode == M_SCALED) ? ti1 + ti2 : plain(mode, acc);
  end
endmodule
`default_nettype wire

/* core/ifdt_top.sv */
// Instruction field decoder, cycle-cost model and FPU operand mover
`timescale 1ns/10ps
`default_nettype none
module ifdt_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic [31:0] fpu_data,
  output logic fpu_valid,
  input wire logic fpu_done,
  input wire logic [31:0] fpu_rdata,
  input wire logic fpu_rvalid,
  output logic trap_undef,
  output logic cond_true
);
  import ifdt_pkg::*;

  typedef enum logic [1:0] {F_IDLE, F_SEND, F_WAIT} ifdt_fst_t;
  typedef struct packed {
    logic ph_wr;
    logic [7:0] ph_addr;
    logic [31:0] rdata;
    logic ready;
    logic resp;
    logic [15:0] instr;
    ifdt_flags_t flags;
    ifdt_opnd_t opnd;
    ifdt_str_t strcfg;
    logic fstd;
    logic [31:0] flo;
    logic [31:0] fhi;
    logic [31:0] rlo;
    logic [31:0] rhi;
    ifdt_fst_t fsm;
    logic piece;
    logic rsel;
    logic [15:0] fcnt;
    logic [15:0] fexec;
    logic [31:0] fdata;
    logic fvalid;
    logic trap;
    logic ctrue;
  } ifdt_state_t;

  ifdt_state_t s;
  ifdt_state_t next_s;
  logic acc;
  logic fmt0;
  logic fmt2;
  logic quick;
  logic isded;
  logic resv;
  logic hit;
  logic start;
  logic [2:0] op;
  logic [3:0] sh;
  logic [3:0] cc;
  logic [1:0] len;
  logic [31:0] sx;
  logic [31:0] immv;
  logic [31:0] rv;
  logic [7:0] tea1;
  logic [7:0] tea2;
  logic [7:0] top1;
  logic [7:0] top2;
  logic [9:0] serial;
  logic [9:0] ovl;
  logic [4:0] lim;
  logic [4:0] hidden;
  logic [13:0] strw;
  ifdt_dec_t dc;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  ifdt_cond u_cond (
    .code(cc),
    .eq(s.flags.eq),
    .borrow(s.flags.borrow),
    .above(s.flags.above),
    .sgt(s.flags.sgt),
    .aux(s.flags.aux),
    .hit(hit)
  );
  ifdt_tea u_tea1 (
    .mode(s.opnd.m1),
    .base(s.opnd.b1),
    .scale(s.opnd.sc1),
    .acc(X_READ),
    .tea(tea1)
  );
  ifdt_tea u_tea2 (
    .mode(s.opnd.m2),
    .base(s.opnd.b2),
    .scale(s.opnd.sc2),
    .acc(s.opnd.rmw2 ? X_RMW : X_WRITE),
    .tea(tea2)
  );

  function automatic logic [7:0] top_f(input logic [2:0] m,
                                       input logic [1:0] l,
                                       input logic [1:0] nc);
    logic [7:0] n8;
    n8 = (nc == 2'h0) ? 8'h01 : {6'h00, nc};
    if (m == M_REG || m == M_IMM) begin
      top_f = 8'h00;
    end else if (l == LEN_B) begin
      top_f = T_TOPB;
    end else begin
      top_f = T_BUSCYC * n8 - T_BUSADJ;
    end
  endfunction

  function automatic logic [9:0] mx(input logic [9:0] a,
                                    input logic [9:0] b);
    mx = (a > b) ? a : b;
  endfunction

  always_comb begin
    next_s = s;
    len = s.instr[1:0];
    op = s.instr[6:4];
    sh = s.instr[10:7];
    fmt0 = s.instr[3:0] == FMT0_KEY;
    fmt2 = s.instr[3:2] == FMT2_KEY && op != OP_F3;
    dc = '0;
    dc.len1h = {len == LEN_D, len == LEN_W, len == LEN_B};
    dc.fstd = s.fstd;
    cc = fmt0 ? s.instr[7:4] : sh;
    dc.cvalid = fmt0 || (fmt2 && op == OP_SCOND);
    dc.ctrue = dc.cvalid && hit;
    quick = fmt2 && (op == OP_MOVE_QUICK || op == OP_ADD_QUICK ||
                     op == OP_COMPARE_QUICK || op == OP_ACB);
    dc.quick = quick;
    sx = {{28{sh[3]}}, sh};
    case (len)
      LEN_B: immv = {24'h000000, sx[7:0]};
      LEN_W: immv = {16'h0000, sx[15:0]};
      default: immv = sx;
    endcase
    if (!quick) begin
      immv = RST_WORD;
    end
    isded = fmt2 && (op == OP_LPR || op == OP_SPR);
    case (sh)
      DR_USB, DR_FP, DR_SP, DR_SB, DR_PSR, DR_VTB, DR_DTP: resv = 1'b0;
      default: resv = 1'b1;
    endcase
    dc.dvalid = isded && !resv;
    dc.dsel = dc.dvalid ? sh : 4'h0;
    dc.trap = isded && resv;
    next_s.trap = dc.trap;
    next_s.ctrue = dc.ctrue;

    top1 = top_f(s.opnd.m1, len, s.opnd.nc1);
    top2 = top_f(s.opnd.m2, len, s.opnd.nc2);
    serial = {2'h0, tea1} + {2'h0, tea2} + {2'h0, top1} +
             {2'h0, top2} + {2'h0, s.opnd.tcy};
    if (s.opnd.rmw2) begin
      serial = serial + {2'h0, top2};
    end
    ovl = {2'h0, tea1} + mx({2'h0, top1}, {2'h0, tea2}) +
          mx({2'h0, top2}, {2'h0, s.opnd.tcy});

    lim = (s.strcfg.kind == 2'h3) ? HIDE_D : HIDE_BW;
    if (s.strcfg.kind == 2'h0) begin
      hidden = 5'h00;
    end else begin
      hidden = (s.strcfg.waits > lim) ? lim : s.strcfg.waits;
    end
    strw = {s.strcfg.transl, s.strcfg.back,
            s.strcfg.rep == REP_UNTIL, s.strcfg.rep == REP_WHILE,
            s.strcfg.waits - hidden, hidden};

    // Derived registers read from live decode, so a read right
    // after a write already sees the new fields
    case (haddr[7:0])
      A_INSTR: rv = {16'h0000, s.instr};
      A_FLAGS: rv = {27'h0000000, s.flags};
      A_OPND: rv = s.opnd;
      A_STRCFG: rv = {19'h00000, s.strcfg};
      A_FLO: rv = s.flo;
      A_FHI: rv = s.fhi;
      A_FCTRL: rv = {30'h00000000, s.fstd, 1'b0};
      A_DEC: rv = {19'h00000, dc};
      A_IMM: rv = immv;
      A_TEA: rv = {top2, top1, tea2, tea1};
      A_TOTAL: rv = {6'h00, ovl, 6'h00, serial};
      A_STRST: rv = {18'h00000, strw};
      A_FSTAT: rv = {s.fexec, 14'h0000, s.fstd, s.fsm != F_IDLE};
      A_RLO: rv = s.rlo;
      A_RHI: rv = s.rhi;
      default: rv = RST_WORD;
    endcase

    // Zero-wait slave: address captured, data phase next cycle
    acc = hsel && hready && htrans[1];
    next_s.ph_wr = acc && hwrite && haddr[31:8] == 24'h000000 &&
                   hsize == SZ_WORD;
    next_s.ph_addr = haddr[7:0];
    next_s.rdata = (acc && !hwrite && haddr[31:8] == 24'h000000) ?
                   rv : RST_WORD;
    if (s.ph_wr) begin
      case (s.ph_addr)
        A_INSTR: next_s.instr = hwdata[15:0];
        A_FLAGS: next_s.flags = hwdata[4:0];
        A_OPND: next_s.opnd = hwdata;
        A_STRCFG: next_s.strcfg = hwdata[12:0];
        A_FLO: next_s.flo = hwdata;
        A_FHI: next_s.fhi = hwdata;
        A_FCTRL: begin
          // Size is frozen while a transfer is in flight
          if (s.fsm == F_IDLE) begin
            next_s.fstd = hwdata[1];
          end
        end
        default: next_s.instr = s.instr;
      endcase
    end

    start = s.ph_wr && s.ph_addr == A_FCTRL && hwdata[0] &&
            s.fsm == F_IDLE;
    next_s.fvalid = 1'b0;
    case (s.fsm)
      F_IDLE: begin
        if (start) begin
          next_s.fsm = F_SEND;
          next_s.piece = 1'b0;
          next_s.rsel = 1'b0;
          next_s.fcnt = 16'h0000;
        end
      end
      F_SEND: begin
        next_s.fvalid = 1'b1;
        next_s.fdata = s.piece ? s.fhi : s.flo;
        if (s.piece || s.fstd) begin
          next_s.fsm = F_WAIT;
        end else begin
          next_s.piece = 1'b1;
        end
      end
      F_WAIT: begin
        if (fpu_done) begin
          next_s.fexec = s.fcnt;
          next_s.fsm = F_IDLE;
        end else if (s.fcnt != 16'hFFFF) begin
          next_s.fcnt = s.fcnt + 16'h0001;
        end
      end
      default: next_s.fsm = F_IDLE;
    endcase
    if (fpu_rvalid) begin
      if (s.rsel) begin
        next_s.rhi = fpu_rdata;
      end else begin
        next_s.rlo = fpu_rdata;
      end
      next_s.rsel = !s.rsel;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
      s.ready <= 1'b1;
      s.fsm <= F_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign hreadyout = s.ready;
  assign hresp = s.resp;
  assign hrdata = s.rdata;
  assign fpu_data = s.fdata;
  assign fpu_valid = s.fvalid;
  assign trap_undef = s.trap;
  assign cond_true = s.ctrue;

  a_len_invalid: assert property (
    len == 2'h2 |-> dc.len1h == 3'h0)
    else $error("reserved length decoded as a size");
  a_cond_eq: assert property (
    fmt0 && s.instr[7:4] == 4'h0 |=> cond_true == $past(s.flags.eq))
    else $error("equal condition does not follow flag");
  a_cond_lo: assert property (
    fmt0 && s.instr[7:4] == 4'hA && !s.flags.above && !s.flags.eq
    |=> cond_true)
    else $error("lower condition missed");
  a_cond_const: assert property (
    fmt0 && s.instr[7:4] == 4'hF |=> !cond_true)
    else $error("never condition reported true");
  a_imm_byte: assert property (
    quick && len == LEN_B && sh == 4'hF |-> immv == 32'h000000FF)
    else $error("byte quick value badly extended");
  a_trap_resv: assert property (
    fmt2 && op == OP_LPR && sh == 4'hB |=> trap_undef)
    else $error("reserved selector did not trap");
  a_top_byte: assert property (
    s.opnd.m1 == M_TOS && len == LEN_B |-> top1 == 8'h03)
    else $error("byte transfer cost wrong");
  a_top_word: assert property (
    s.opnd.m2 == M_REL && len == LEN_W && s.opnd.nc2 == 2'h2
    |-> top2 == 8'h07)
    else $error("word transfer cost wrong");
  a_tea_scaled: assert property (
    s.opnd.m1 == M_SCALED && s.opnd.b1 == M_REG && s.opnd.sc1 == 2'h1
    |-> tea1 == 8'h0C)
    else $error("scaled address time wrong");
  a_hide_limit: assert property (
    s.strcfg.kind == 2'h1 && s.strcfg.waits == 5'h1F
    |-> hidden == 5'h0D)
    else $error("hidden wait limit wrong");
  a_fpu_std: assert property (
    start && hwdata[1] |=> ##1 fpu_valid ##1 !fpu_valid)
    else $error("single piece transfer wrong");
  a_fpu_long: assert property (
    start && !hwdata[1] |=> ##1 fpu_valid [*2] ##1 !fpu_valid)
    else $error("two piece transfer wrong");
  c_fpu_done: cover property (s.fsm == F_WAIT && fpu_done);
  c_trap: cover property (trap_undef);
  c_cond: cover property (dc.cvalid && !fmt0 && cond_true);
endmodule
`default_nettype wire

/* sim/ifdt_fpu_model.sv */
// Behavioural floating-point slave facing the decoder's operand link
`timescale 1ns/10ps
`default_nettype none
module ifdt_fpu_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [31:0] fpu_data,
  input wire logic fpu_valid,
  output logic fpu_done,
  output logic [31:0] fpu_rdata,
  output logic fpu_rvalid,
  input wire logic [1:0] need,
  input wire logic [7:0] lat,
  input wire logic [31:0] res_lo,
  input wire logic [31:0] res_hi,
  output logic [3:0] n,
  output logic [31:0] prev,
  output logic [31:0] last
);
  logic [1:0] got;
  logic [7:0] cnt;
  logic [1:0] rq;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fpu_done <= 1'b0;
      fpu_rvalid <= 1'b0;
      fpu_rdata <= 32'h0;
      got <= 2'h0;
      cnt <= 8'h0;
      rq <= 2'h0;
      n <= 4'h0;
      prev <= 32'h0;
      last <= 32'h0;
    end else begin
      fpu_done <= 1'b0;
      fpu_rvalid <= 1'b0;
      // Released result line toggles so a stale value cannot pass
      fpu_rdata <= ~fpu_rdata;
      if (fpu_valid) begin
        prev <= last;
        last <= fpu_data;
        n <= n + 4'h1;
        got <= (got + 2'h1 == need) ? 2'h0 : got + 2'h1;
        if (got + 2'h1 == need) cnt <= lat - 8'h1;
      end
      if (cnt == 8'h1) begin
        fpu_done <= 1'b1;
        rq <= need;
      end
      if (cnt != 8'h0) cnt <= cnt - 8'h1;
      if (rq != 2'h0) begin
        fpu_rvalid <= 1'b1;
        fpu_rdata <= (rq == need) ? res_lo : res_hi;
        rq <= rq - 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* sim/tb_instr_field_decode_timing.sv */
// Self-checking bench for the instruction field decoder
`timescale 1ns/10ps
`default_nettype none
module tb_instr_field_decode_timing;
  import ifdt_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, fpu_data, fpu_rdata;
  logic [1:0] htrans, need;
  logic [2:0] hsize;
  logic fpu_valid, fpu_done, fpu_rvalid, trap_undef, cond_true;
  logic [7:0] lat;
  logic [31:0] res_lo, res_hi, prev, last;
  logic [3:0] n;
  int mismatches = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [31:0] od [6] = '{32'h03000200, 32'h05180301, 32'h02130504,
    32'h0105AE46, 32'h0000DE05, 32'h090A0502};
  logic [1:0] ln [6] = '{LEN_B, LEN_W, LEN_D, LEN_W, LEN_B, LEN_D};
  logic [31:0] te [6] = '{32'h03000402, 32'h07000504, 32'h030B0305,
    32'h03030C0C, 32'h03030F02, 32'h07070404};
  logic [31:0] tt [6] = '{32'h0009000C, 32'h0010001C, 32'h0013001B,
    32'h001B001F, 32'h00140017, 32'h0014001F};
  ifdt_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .fpu_data(fpu_data),
    .fpu_valid(fpu_valid), .fpu_done(fpu_done), .fpu_rdata(fpu_rdata),
    .fpu_rvalid(fpu_rvalid), .trap_undef(trap_undef),
    .cond_true(cond_true));
  ifdt_fpu_model fpu_u (.hclk(hclk), .hresetn(hresetn),
    .fpu_data(fpu_data), .fpu_valid(fpu_valid), .fpu_done(fpu_done),
    .fpu_rdata(fpu_rdata), .fpu_rvalid(fpu_rvalid), .need(need),
    .lat(lat), .res_lo(res_lo), .res_hi(res_hi), .n(n), .prev(prev),
    .last(last));
  always #10 hclk = ~hclk;
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Generous ceiling over the roughly 7k cycles the tests need
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 60000) begin
      mismatches++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [2:0] sz, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= sz;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, SZ_WORD, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(a, 1'b0, SZ_WORD, 32'h0, q);
  endtask
  function automatic logic cexp(input logic [3:0] c, input logic [4:0] f);
    logic [7:0] s;
    s = {1'b1, ~(f[3] | f[0]), ~(f[2] | f[0]), f[4], f[3:0]};
    return s[c[3:1]] ^ c[0];
  endfunction
  task automatic t_bus();
    logic [31:0] q;
    chk({30'h0, hresp, hreadyout}, 32'h1, "idle response");
    rd(A_INSTR, q);
    chk(q, RST_WORD, "instr reset");
    wr(A_INSTR, 32'h000000AA);
    bus(A_INSTR, 1'b1, 3'h0, 32'h55, q);
    rd(A_INSTR, q);
    chk(q, 32'hAA, "byte write");
    wr(8'h1C, 32'hFFFFFFFF);
    rd(8'h1C, q);
    chk(q, 32'h0, "unmapped");
    $display("test bus done");
  endtask
  task automatic t_quick();
    logic [31:0] q, e;
    logic [2:0] ops [4] = '{OP_ADD_QUICK, OP_COMPARE_QUICK, OP_ACB, OP_MOVE_QUICK};
    logic [3:0] sv [4] = '{4'h8, 4'h7, 4'hF, 4'h1};
    logic [1:0] lz [3] = '{LEN_B, LEN_W, LEN_D};
    for (int i = 0; i < 4; i++) begin
      for (int j = 0; j < 3; j++) begin
        wr(A_INSTR, {21'h0, sv[i], ops[i], 2'h3, lz[j]});
        rd(A_DEC, q);
        chk({28'h0, q[12], q[2:0]}, {28'h0, 1'b1, 3'b001 << j}, "len");
        e = {{28{sv[i][3]}}, sv[i]};
        if (j == 0) e = e & 32'hFF;
        if (j == 1) e = e & 32'hFFFF;
        rd(A_IMM, q);
        chk(q, e, "quick value");
      end
    end
    $display("test quick done");
  endtask
  task automatic t_cond();
    logic [31:0] q;
    logic e;
    for (int f = 0; f < 32; f++) begin
      wr(A_FLAGS, f);
      for (int c = 0; c < 32; c++) begin
        wr(A_INSTR, c[4] ? {21'h0, c[3:0], OP_SCOND, 2'h3, LEN_B}
                         : {24'h0, c[3:0], 4'hA});
        rd(A_DEC, q);
        e = cexp(c[3:0], f[4:0]);
        chk({29'h0, q[5], cond_true, q[4]}, {29'h0, 1'b1, e, e},
            "cond");
      end
    end
    $display("test cond done");
  endtask
  task automatic t_dreg();
    logic [31:0] q;
    logic e;
    for (int k = 0; k < 32; k++) begin
      wr(A_INSTR, {21'h0, k[3:0], k[4] ? OP_LPR : OP_SPR, 2'h3, LEN_D});
      rd(A_DEC, q);
      e = 1'((16'h18FE >> k[3:0]) & 16'h1);
      chk({26'h0, trap_undef, q[11], q[9:6] & {4{~e}}},
          {26'h0, e, e, k[3:0] & {4{~e}}}, "dedicated");
    end
    wr(A_INSTR, {21'h0, 4'h1, OP_MOVE_QUICK, 2'h3, LEN_D});
    rd(A_DEC, q);
    chk({31'h0, trap_undef}, 32'h0, "no trap on quick");
    $display("test dedicated done");
  endtask
  task automatic t_str();
    logic [31:0] q;
    logic [4:0] ws [6] = '{5'd0, 5'd4, 5'd5, 5'd13, 5'd14, 5'd31};
    logic [1:0] rs [3] = '{2'h0, REP_WHILE, REP_UNTIL};
    logic [4:0] h, lim;
    logic [1:0] rp;
    for (int k = 1; k < 4; k++) begin
      for (int i = 0; i < 6; i++) begin
        rp = rs[i % 3];
        wr(A_STRCFG, {19'h0, ws[i], 2'h0, k[1:0], i[1], i[0], rp});
        lim = (k == 3) ? HIDE_D : HIDE_BW;
        h = (ws[i] < lim) ? ws[i] : lim;
        rd(A_STRST, q);
        chk(q, {18'h0, i[1], i[0], rp == REP_UNTIL, rp == REP_WHILE,
            ws[i] - h, h}, "string");
      end
    end
    $display("test string done");
  endtask
  task automatic t_tea();
    logic [31:0] q;
    for (int i = 0; i < 6; i++) begin
      wr(A_INSTR, {21'h0, 4'h1, OP_MOVE_QUICK, 2'h3, ln[i]});
      wr(A_OPND, od[i]);
      rd(A_TEA, q);
      chk(q, te[i], "address time");
      rd(A_TOTAL, q);
      chk(q & 32'h03FF03FF, tt[i], "totals");
    end
    $display("test timing done");
  endtask
  task automatic fpu_run(input logic lng, input logic [7:0] l);
    logic [31:0] q;
    logic [3:0] n0;
    int t;
    need <= lng ? 2'h2 : 2'h1;
    lat <= l;
    n0 = n;
    wr(A_FLO, 32'h3F800001);
    wr(A_FHI, 32'hC0000002);
    wr(A_FCTRL, {30'h0, ~lng, 1'b1});
    // Second start lands while busy and must not send pieces
    wr(A_FCTRL, 32'h3);
    t = 0;
    do begin
      rd(A_FSTAT, q);
      t++;
    end while (q[0] !== 1'b0 && t < 80);
    chk({q[31:16], 14'h0, q[1:0]}, {8'h0, l, 14'h0, ~lng, 1'b0},
        "status");
    chk({28'h0, n - n0}, {28'h0, lng ? 4'h2 : 4'h1}, "pieces");
    chk(lng ? prev : last, 32'h3F800001, "low piece");
    if (lng) chk(last, 32'hC0000002, "high piece");
    rd(A_RLO, q);
    chk(q, res_lo, "result low");
    if (lng) begin
      rd(A_RHI, q);
      chk(q, res_hi, "result high");
    end
    $display("test fpu done");
  endtask
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = SZ_WORD;
    hwdata = 32'h0;
    need = 2'h1;
    lat = 8'h2;
    res_lo = 32'h13579BDF;
    res_hi = 32'h2468ACE0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    t_bus();
    t_quick();
    t_cond();
    t_dreg();
    t_str();
    t_tea();
    fpu_run(1'b0, 8'd20);
    fpu_run(1'b1, 8'd2);
    print_verdict();
  end
endmodule
`default_nettype wire
